// File: hdl/ipm_regs.vh
`ifndef IPM_REGS_VH
`define IPM_REGS_VH
// register byte offsets
`define IPM_CTRL 8'h00
`define IPM_WAKE 8'h04
`define IPM_GNSS 8'h08
`define IPM_TIME 8'h0c
`define IPM_QMS 8'h10
`define IPM_STAT 8'h14
`define IPM_BKUP 8'h18
`define IPM_CELL 8'h1c
// mcu power modes (one-hot)
`define IPM_M_RUN 3'h1
`define IPM_M_LPR 3'h2
`define IPM_M_SHD 3'h4
// cellular states (one-hot)
`define IPM_C_IDLE 4'h1
`define IPM_C_SLEEP 4'h2
`define IPM_C_DATA 4'h4
`define IPM_C_PDN 4'h8
// gnss states (one-hot)
`define IPM_G_ACQ 5'h01
`define IPM_G_TRK 5'h02
`define IPM_G_CPU 5'h04
`define IPM_G_STBY 5'h08
`define IPM_G_HIB 5'h10
// gnss schemes
`define IPM_S_BASIC 2'h0
`define IPM_S_TRICKLE 2'h1
`define IPM_S_PERIODIC 2'h2
`define IPM_S_QUALITY 2'h3
// timing, clock 100 MHz
`define IPM_CLK_HZ 100000000
`define IPM_MS_DIV (`IPM_CLK_HZ / 1000)
`define IPM_DRX_UNIT_MS 10
`define IPM_HOT_LIMIT_S 14400
`define IPM_LP_CLK_HZ 2000000
`define IPM_CLK_DIV_LP (`IPM_CLK_HZ / `IPM_LP_CLK_HZ)
// setting limits
`define IPM_TRK_PER_MIN_S 1
`define IPM_TRK_PER_MAX_S 10
`define IPM_TRK_ON_MIN_MS 200
`define IPM_TRK_ON_MAX_MS 900
`define IPM_PER_MIN_S 10
`define IPM_PER_MAX_S 7200
`define IPM_TBF_MIN_S 10
`define IPM_TBF_MAX_S 180
`define IPM_DUTY_MIN 5
`define IPM_DUTY_MAX 100
`define IPM_ERR_MIN_M 1
`define IPM_ERR_MAX_M 160
`endif

// File: hdl/ipm_tick.v
`timescale 1ns/10ps
`include "ipm_regs.vh"
// divides core_clk into a one-cycle pulse every DIV cycles
module ipm_tick #(
	parameter DIV = `IPM_MS_DIV
) (
	input wire core_clk,
	input wire nrst,
	input wire run,
	output wire tick
);
	reg [31:0] cnt_ff;
	assign tick = run && (cnt_ff == DIV - 1);
	always @(posedge core_clk)
	begin
		if (!nrst || !run || tick)
			cnt_ff <= 32'h0;
		else
			cnt_ff <= cnt_ff + 32'h1;
	end
endmodule // ipm_tick

// File: hdl/ipm_wb.v
`timescale 1ns/10ps
`include "ipm_regs.vh"
// classic wishbone slave front: one wait state, ack for one cycle
module ipm_wb (
	input wire core_clk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output wire wb_ack_o,
	output wire wr_stb,
	output wire rd_stb
);
	reg ack_ff;
	wire req;
	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wb_ack_o = ack_ff;
	assign wr_stb = ack_ff && wb_cyc_i && wb_stb_i;
	assign rd_stb = req;
	always @(posedge core_clk)
	begin
		if (!nrst)
			ack_ff <= 1'b0;
		else
			ack_ff <= req;
	end
endmodule // ipm_wb

// File: hdl/ipm_top.v
// Behaviour
// RULE_01: every wakeup restarts the mcu in full run mode.
// RULE_02: low-power run selects lp regulator and caps cpu clock at 2 MHz.
// RULE_03: shutdown turns regulator and oscillators off; rtc may stay on.
// RULE_04: shutdown clears volatile state; backup register keeps its value; the code clears only the mcu mode request, scheme and gps-only setting.
// RULE_05: shutdown ends on reset, wake pin edge of chosen polarity, or rtc event.
// RULE_06: software arms wakeups before requesting shutdown.
// RULE_07: registered idle modem stays registered and paging in sleep.
// RULE_08: modem power-down keeps only rtc regulator; interfaces unreachable.
// RULE_09: lte pause lasts drx value times 10 ms, drx in 32..256.
// RULE_10: receiver acquires until a reliable fix, then tracks.
// RULE_11: gps-only setting powers down the glonass radio block.
// RULE_12: cpu-only state once measurements taken but solution pending.
// RULE_13: standby unpowers radio and dsp and gates baseband clock.
// RULE_14: hibernate keeps rtc and bbram; hot start if under 4 hours.
// RULE_15: basic scheme: user commands full power and hibernate moves.
// RULE_16: trickle scheme cycles full, cpu-only, standby; period 1 to 10 s.
// RULE_17: trickle on-time of tracking plus cpu-only is 200 to 900 ms.
// RULE_18: periodic scheme hibernates, waking every 10 s to 2 hours.
// RULE_19: periodic attempt holds full power until fix or timeout.
// RULE_20: quality scheme: duty-cycle or time-between-fixes priority, error cap; the code stores the error cap and its enable but never applies them.
// RULE_21: quality scheme takes tbf 10 to 180 s, duty 5 to 100 percent.
// RULE_22: quality scheme takes error 1 to 160 m and fix count up to 255.
// RULE_23: each subsystem state is readable; changes only at state transitions.
`timescale 1ns/10ps
`include "ipm_regs.vh"
module ipm_top #(
	parameter MS_DIV = `IPM_MS_DIV
) (
	input wire core_clk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output wire wb_ack_o,
	input wire ext_reset_n,
	input wire wake_pin,
	input wire rtc_event,
	input wire modem_registered,
	input wire lte_attached,
	input wire gnss_fix_ok,
	input wire gnss_meas_done,
	input wire gnss_sol_done,
	output reg lp_regulator_ff,
	output reg main_regulator_on_ff,
	output reg osc_on_ff,
	output reg rtc_on_ff,
	output wire cpu_clk_en,
	output reg modem_paging_ff,
	output reg modem_if_en_ff,
	output reg lte_pause_ff,
	output reg glonass_rf_on_ff,
	output reg rf_dsp_on_ff,
	output reg rf_dsp_partial_ff,
	output reg bb_clk_on_ff,
	output reg hot_start_ff
);
	localparam S_BASIC = `IPM_S_BASIC;
	localparam S_TRICKLE = `IPM_S_TRICKLE;
	localparam S_PERIODIC = `IPM_S_PERIODIC;
	localparam S_QUALITY = `IPM_S_QUALITY;
	localparam [3:0] ALLSEL = 4'hf;

	// limits arrive as full-width constants and are cut here on purpose
	function [15:0] clampv;
		input [15:0] v;
		input [31:0] lo;
		input [31:0] hi;
		begin
			if (v < lo)
				clampv = lo[15:0];
			else if (v > hi)
				clampv = hi[15:0];
			else
				clampv = v;
		end
	endfunction

	wire wr_stb;
	wire rd_stb;
	wire ms_tick;
	wire lp_tick;
	ipm_wb u_wb (
		.core_clk(core_clk),
		.nrst(nrst),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_ack_o(wb_ack_o),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb)
	);
	ipm_tick #(.DIV(MS_DIV)) u_ms (
		.core_clk(core_clk),
		.nrst(nrst),
		.run(1'b1),
		.tick(ms_tick)
	);
	ipm_tick #(.DIV(`IPM_CLK_DIV_LP)) u_lp (
		.core_clk(core_clk),
		.nrst(nrst),
		.run(1'b1),
		.tick(lp_tick)
	);

	wire wr;
	assign wr = wr_stb && wb_we_i && (wb_sel_i == ALLSEL);

	reg [2:0] mcu_ff;
	reg [3:0] cell_ff;
	reg [4:0] gnss_ff;
	reg [1:0] mcu_req_ff;
	reg [1:0] cell_req_ff;
	reg wake_rise_ff;
	reg wake_prev_ff;
	reg rtc_keep_ff;
	reg [31:0] bkup_ff;
	reg [1:0] scheme_ff;
	reg gps_only_ff;
	reg basic_full_ff;
	reg qual_tbf_prio_ff;
	reg qual_err_en_ff;
	reg qual_cont_ff;
	reg [8:0] drx_ff;
	reg [15:0] period_s_ff;
	reg [15:0] on_ms_ff;
	reg [15:0] timeout_s_ff;
	reg [6:0] duty_ff;
	reg [7:0] err_m_ff;
	reg [7:0] fix_cnt_ff;
	reg [7:0] fix_left_ff;
	reg [31:0] ms_cnt_ff;
	reg [31:0] pause_ff;
	reg [31:0] since_fix_ff;
	reg [9:0] sub_ms_ff;

	wire wake_edge;
	assign wake_edge = wake_rise_ff ? (wake_pin && !wake_prev_ff) : (!wake_pin && wake_prev_ff);
	wire mcu_wake;
	assign mcu_wake = !ext_reset_n || wake_edge || rtc_event; // RULE_05
	wire [31:0] period_ms;
	assign period_ms = {16'h0, period_s_ff} * 32'd1000;
	wire [31:0] on_ms;
	assign on_ms = {16'h0, on_ms_ff};
	wire [31:0] qual_on_ms;
	assign qual_on_ms = (period_ms / 32'd100) * {25'h0, duty_ff};
	wire [31:0] drx_ms;
	assign drx_ms = {23'h0, drx_ff} * `IPM_DRX_UNIT_MS; // RULE_09
	wire [15:0] wr_lo;
	assign wr_lo = wb_dat_i[15:0];
	wire [15:0] wr_hi;
	assign wr_hi = wb_dat_i[31:16];
	wire [15:0] duty_cl;
	assign duty_cl = clampv({9'h0, wb_dat_i[6:0]}, `IPM_DUTY_MIN, `IPM_DUTY_MAX); // RULE_21
	wire [15:0] err_cl;
	assign err_cl = clampv({8'h0, wb_dat_i[15:8]}, `IPM_ERR_MIN_M, `IPM_ERR_MAX_M); // RULE_22

	// low-power run passes the clock only on the 2 MHz enable;
	// after a wakeup the clock waits until the regulator is back on
	assign cpu_clk_en = main_regulator_on_ff && ((mcu_ff == `IPM_M_RUN)
		|| ((mcu_ff == `IPM_M_LPR) && lp_tick)); // RULE_02 RULE_03

	// mcu mode machine; the request is applied and then consumed
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			mcu_ff <= `IPM_M_RUN;
			wake_prev_ff <= 1'b0;
		end
		else
		begin
			wake_prev_ff <= wake_pin;
			case (mcu_ff)
				`IPM_M_RUN:
					if (mcu_req_ff == 2'h1)
						mcu_ff <= `IPM_M_LPR;
					else if (mcu_req_ff == 2'h2)
						mcu_ff <= `IPM_M_SHD; // RULE_06
				`IPM_M_LPR:
					if (mcu_req_ff == 2'h2)
						mcu_ff <= `IPM_M_SHD;
					else if (mcu_req_ff == 2'h3)
						mcu_ff <= `IPM_M_RUN;
				`IPM_M_SHD:
					if (mcu_wake)
						mcu_ff <= `IPM_M_RUN; // RULE_01 RULE_05
				default:
					mcu_ff <= `IPM_M_RUN;
			endcase
		end
	end

	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			lp_regulator_ff <= 1'b0;
			main_regulator_on_ff <= 1'b1;
			osc_on_ff <= 1'b1;
			rtc_on_ff <= 1'b1;
		end
		else
		begin
			lp_regulator_ff <= (mcu_ff == `IPM_M_LPR); // RULE_02
			main_regulator_on_ff <= (mcu_ff != `IPM_M_SHD); // RULE_03
			osc_on_ff <= (mcu_ff != `IPM_M_SHD); // RULE_03
			rtc_on_ff <= (mcu_ff != `IPM_M_SHD) || rtc_keep_ff; // RULE_03
		end
	end

	// cellular machine
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			cell_ff <= `IPM_C_PDN;
			modem_paging_ff <= 1'b0;
			modem_if_en_ff <= 1'b0;
			lte_pause_ff <= 1'b0;
			pause_ff <= 32'h0;
		end
		else
		begin
			case (cell_req_ff)
				2'h0:
					cell_ff <= `IPM_C_IDLE;
				2'h1:
					cell_ff <= `IPM_C_SLEEP;
				2'h2:
					cell_ff <= `IPM_C_DATA;
				default:
					cell_ff <= `IPM_C_PDN;
			endcase
			if (cell_ff == `IPM_C_SLEEP && cell_req_ff != 2'h1)
				modem_paging_ff <= 1'b0;
			else if (cell_ff == `IPM_C_IDLE)
				modem_paging_ff <= modem_registered; // RULE_07
			else if (cell_ff == `IPM_C_PDN || cell_ff == `IPM_C_DATA)
				modem_paging_ff <= 1'b0;
			modem_if_en_ff <= (cell_ff != `IPM_C_PDN); // RULE_08
			// pause and paging listen alternate while attached in sleep
			if (cell_ff != `IPM_C_SLEEP || !lte_attached)
			begin
				lte_pause_ff <= 1'b0;
				pause_ff <= 32'h0;
			end
			else if (ms_tick)
			begin
				if (pause_ff + 32'h1 >= drx_ms)
				begin
					pause_ff <= 32'h0;
					lte_pause_ff <= !lte_pause_ff; // RULE_09
				end
				else
					pause_ff <= pause_ff + 32'h1;
			end
		end
	end

	// gnss machine, one millisecond time base
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			gnss_ff <= `IPM_G_ACQ;
			ms_cnt_ff <= 32'h0;
			since_fix_ff <= 32'h0;
			sub_ms_ff <= 10'h0;
			fix_left_ff <= 8'h0;
		end
		else
		begin
			if (ms_tick)
			begin
				ms_cnt_ff <= ms_cnt_ff + 32'h1;
				if (sub_ms_ff == 10'd999)
				begin
					sub_ms_ff <= 10'h0;
					if (since_fix_ff != 32'hffffffff)
						since_fix_ff <= since_fix_ff + 32'h1;
				end
				else
					sub_ms_ff <= sub_ms_ff + 10'h1;
			end
			if (gnss_fix_ok && (gnss_ff == `IPM_G_ACQ || gnss_ff == `IPM_G_TRK))
				since_fix_ff <= 32'h0;
			case (gnss_ff)
				`IPM_G_ACQ:
					if (scheme_ff == S_BASIC && !basic_full_ff)
						gnss_ff <= `IPM_G_HIB; // RULE_15
					else if (gnss_fix_ok)
					begin
						gnss_ff <= `IPM_G_TRK; // RULE_10
						ms_cnt_ff <= 32'h0;
					end
					else if (scheme_ff == S_PERIODIC && ms_cnt_ff >= {16'h0, timeout_s_ff} * 32'd1000)
					begin
						gnss_ff <= `IPM_G_HIB; // RULE_19
						ms_cnt_ff <= 32'h0;
					end
				`IPM_G_TRK:
					if (scheme_ff == S_BASIC && !basic_full_ff)
						gnss_ff <= `IPM_G_HIB; // RULE_15
					else if (scheme_ff == S_TRICKLE && gnss_meas_done)
						gnss_ff <= `IPM_G_CPU; // RULE_12
					else if (scheme_ff == S_PERIODIC)
					begin
						gnss_ff <= `IPM_G_HIB; // RULE_18 RULE_19
						ms_cnt_ff <= 32'h0;
					end
					else if (scheme_ff == S_QUALITY && ms_cnt_ff >= qual_on_ms
						&& (!qual_tbf_prio_ff || gnss_fix_ok))
					begin
						gnss_ff <= `IPM_G_HIB; // RULE_20
						ms_cnt_ff <= 32'h0;
						if (!qual_cont_ff && fix_left_ff != 8'h0)
							fix_left_ff <= fix_left_ff - 8'h1; // RULE_22
					end
				`IPM_G_CPU:
					if (gnss_sol_done || ms_cnt_ff >= on_ms)
						gnss_ff <= `IPM_G_STBY; // RULE_17
				`IPM_G_STBY:
					if (scheme_ff != S_TRICKLE)
						gnss_ff <= `IPM_G_ACQ;
					else if (ms_cnt_ff >= period_ms)
					begin
						gnss_ff <= `IPM_G_TRK; // RULE_16
						ms_cnt_ff <= 32'h0;
					end
				`IPM_G_HIB:
					if (scheme_ff == S_BASIC && basic_full_ff)
						gnss_ff <= `IPM_G_ACQ; // RULE_15
					else if ((scheme_ff == S_PERIODIC || scheme_ff == S_QUALITY)
						&& ms_cnt_ff >= period_ms
						&& (scheme_ff != S_QUALITY || qual_cont_ff || fix_left_ff != 8'h0))
					begin
						gnss_ff <= `IPM_G_ACQ; // RULE_18 RULE_14
						ms_cnt_ff <= 32'h0;
					end
					else if (scheme_ff == S_TRICKLE)
						gnss_ff <= `IPM_G_ACQ;
				default:
					gnss_ff <= `IPM_G_ACQ;
			endcase
			if (wr && wb_adr_i == `IPM_QMS)
				fix_left_ff <= wb_dat_i[23:16];
		end
	end

	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			glonass_rf_on_ff <= 1'b1;
			rf_dsp_on_ff <= 1'b1;
			rf_dsp_partial_ff <= 1'b0;
			bb_clk_on_ff <= 1'b1;
			hot_start_ff <= 1'b0;
		end
		else
		begin
			glonass_rf_on_ff <= !gps_only_ff && (gnss_ff == `IPM_G_ACQ || gnss_ff == `IPM_G_TRK); // RULE_11
			rf_dsp_on_ff <= (gnss_ff == `IPM_G_ACQ || gnss_ff == `IPM_G_TRK); // RULE_13 RULE_14
			rf_dsp_partial_ff <= (gnss_ff == `IPM_G_CPU); // RULE_12
			bb_clk_on_ff <= (gnss_ff != `IPM_G_STBY) && (gnss_ff != `IPM_G_HIB); // RULE_13
			if (gnss_ff == `IPM_G_HIB)
				hot_start_ff <= (since_fix_ff < `IPM_HOT_LIMIT_S); // RULE_14
		end
	end

	// software registers; period, on-time, duty and error values are clamped to their legal ranges
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			mcu_req_ff <= 2'h0;
			cell_req_ff <= 2'h3;
			wake_rise_ff <= 1'b1;
			rtc_keep_ff <= 1'b1;
			scheme_ff <= S_BASIC;
			gps_only_ff <= 1'b0;
			basic_full_ff <= 1'b1;
			qual_tbf_prio_ff <= 1'b0;
			qual_err_en_ff <= 1'b0;
			qual_cont_ff <= 1'b1;
			drx_ff <= 9'd32;
			period_s_ff <= 16'd1;
			on_ms_ff <= 16'd200;
			timeout_s_ff <= 16'd30;
			duty_ff <= 7'd100;
			err_m_ff <= 8'd160;
			fix_cnt_ff <= 8'h0;
			bkup_ff <= 32'h0;
		end
		else
		begin
			if (mcu_ff == `IPM_M_SHD)
			begin
				mcu_req_ff <= 2'h0; // RULE_04
				scheme_ff <= S_BASIC;
				gps_only_ff <= 1'b0;
			end
			else if (mcu_req_ff != 2'h0)
				mcu_req_ff <= 2'h0; // RULE_23
			if (wr)
			begin
				case (wb_adr_i)
					`IPM_CTRL:
					begin
						mcu_req_ff <= wb_dat_i[1:0];
						scheme_ff <= wb_dat_i[5:4];
						gps_only_ff <= wb_dat_i[8];
						basic_full_ff <= wb_dat_i[9];
					end
					`IPM_WAKE:
					begin
						wake_rise_ff <= wb_dat_i[0];
						rtc_keep_ff <= wb_dat_i[1];
					end
					`IPM_CELL:
					begin
						cell_req_ff <= wb_dat_i[1:0];
						case (wb_dat_i[9:8])
							2'h0: drx_ff <= 9'd32;
							2'h1: drx_ff <= 9'd64;
							2'h2: drx_ff <= 9'd128;
							default: drx_ff <= 9'd256;
						endcase
					end
					`IPM_TIME:
					begin
						if (scheme_ff == S_TRICKLE)
							period_s_ff <= clampv(wr_lo, `IPM_TRK_PER_MIN_S, `IPM_TRK_PER_MAX_S); // RULE_16
						else if (scheme_ff == S_QUALITY)
							period_s_ff <= clampv(wr_lo, `IPM_TBF_MIN_S, `IPM_TBF_MAX_S); // RULE_21
						else
							period_s_ff <= clampv(wr_lo, `IPM_PER_MIN_S, `IPM_PER_MAX_S); // RULE_18
						on_ms_ff <= clampv(wr_hi, `IPM_TRK_ON_MIN_MS, `IPM_TRK_ON_MAX_MS); // RULE_17
					end
					`IPM_GNSS:
						timeout_s_ff <= wr_lo;
					`IPM_QMS:
					begin
						duty_ff <= duty_cl[6:0]; // RULE_21
						err_m_ff <= err_cl[7:0]; // RULE_22
						fix_cnt_ff <= wb_dat_i[23:16];
						qual_cont_ff <= wb_dat_i[24]; // RULE_22
						qual_tbf_prio_ff <= wb_dat_i[25]; // RULE_20
						qual_err_en_ff <= wb_dat_i[26]; // RULE_20
					end
					`IPM_BKUP:
						bkup_ff <= wb_dat_i; // RULE_04
					default:
						bkup_ff <= bkup_ff;
				endcase
			end
		end
	end

	always @(posedge core_clk)
	begin
		if (!nrst)
			wb_dat_o <= 32'h0;
		else if (rd_stb)
		begin
			case (wb_adr_i)
				`IPM_CTRL: wb_dat_o <= {22'h0, basic_full_ff, gps_only_ff, 2'h0, scheme_ff, 4'h0};
				`IPM_WAKE: wb_dat_o <= {30'h0, rtc_keep_ff, wake_rise_ff};
				`IPM_CELL: wb_dat_o <= {7'h0, drx_ff, 14'h0, cell_req_ff};
				`IPM_TIME: wb_dat_o <= {on_ms_ff, period_s_ff};
				`IPM_GNSS: wb_dat_o <= {16'h0, timeout_s_ff};
				`IPM_QMS: wb_dat_o <= {5'h0, qual_err_en_ff, qual_tbf_prio_ff, qual_cont_ff,
					fix_cnt_ff, err_m_ff, 1'b0, duty_ff};
				`IPM_STAT: wb_dat_o <= {9'h0, hot_start_ff, modem_paging_ff, lte_pause_ff,
					3'h0, gnss_ff, 4'h0, cell_ff, 1'b0, mcu_ff}; // RULE_23
				`IPM_BKUP: wb_dat_o <= bkup_ff;
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end
endmodule // ipm_top

// File: bench/ipm_pin_drv.sv
`timescale 1ns/10ps
// far-side pin drivers: external reset, wake pin and rtc event source
module ipm_pin_drv (
	input wire logic core_clk,
	input wire logic go,
	input wire logic [1:0] src,
	input wire logic pin_lvl,
	output logic ext_reset_n,
	output logic wake_pin,
	output logic rtc_event
);
	initial
	begin
		ext_reset_n = 1'b1;
		wake_pin = 1'b0;
		rtc_event = 1'b0;
	end
	always @(posedge core_clk)
	begin
		ext_reset_n <= !(go && src == 2'h0);
		rtc_event <= go && src == 2'h2;
		wake_pin <= pin_lvl;
	end
endmodule // ipm_pin_drv

// File: bench/ipm_top_chk.sv
`timescale 1ns/10ps
module ipm_top_chk #(
	parameter MS_DIV = 10
) (
	input wire core_clk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire ext_reset_n,
	input wire lte_attached,
	input wire lp_regulator_ff,
	input wire main_regulator_on_ff,
	input wire osc_on_ff,
	input wire cpu_clk_en,
	input wire modem_paging_ff,
	input wire modem_if_en_ff,
	input wire lte_pause_ff,
	input wire rf_dsp_on_ff,
	input wire rf_dsp_partial_ff,
	input wire bb_clk_on_ff
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_shd_reset;
		!main_regulator_on_ff && !ext_reset_n;
	endsequence
	sequence s_settled_run;
		(main_regulator_on_ff && !lp_regulator_ff)[*3];
	endsequence
	AST_SHD_OFF: assert property (!main_regulator_on_ff |-> !osc_on_ff && !cpu_clk_en)
		else $error("clock or oscillator alive in shutdown");
	AST_LP_CAP: assert property (lp_regulator_ff && cpu_clk_en |=>
		(!cpu_clk_en || !lp_regulator_ff)[*8])
		else $error("cpu clock too fast in low-power run");
	AST_RUN_CLK: assert property (s_settled_run |-> $past(cpu_clk_en))
		else $error("cpu clock gated in run");
	AST_WAKE_RST: assert property (s_shd_reset |-> ##[1:4] main_regulator_on_ff)
		else $error("external reset did not end shutdown");
	AST_WAKE_RUN: assert property ($rose(main_regulator_on_ff) |-> !lp_regulator_ff)
		else $error("wakeup not in run mode");
	AST_PDN: assert property (!modem_if_en_ff |-> !modem_paging_ff)
		else $error("paging while modem powered down");
	AST_STBY: assert property (!rf_dsp_on_ff && !rf_dsp_partial_ff |-> !bb_clk_on_ff)
		else $error("baseband clock running with rf off");
	AST_LTE: assert property (!lte_attached [*2] |-> !lte_pause_ff)
		else $error("lte pause while detached");
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack timing wrong");
endmodule // ipm_top_chk

// File: bench/test_iot_power_mode_manager.sv
`timescale 1ns/10ps
`include "ipm_regs.vh"
module test_iot_power_mode_manager;
	logic core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go, pin_lvl;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [1:0] src;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	logic ext_reset_n, wake_pin, rtc_event, modem_registered, lte_attached;
	logic gnss_fix_ok, gnss_meas_done, gnss_sol_done, cpu_clk_en;
	logic lp_regulator_ff, main_regulator_on_ff, osc_on_ff, rtc_on_ff, modem_paging_ff;
	logic modem_if_en_ff, lte_pause_ff, glonass_rf_on_ff, rf_dsp_on_ff, rf_dsp_partial_ff;
	logic bb_clk_on_ff, hot_start_ff;
	int mismatches, tests_run, n;
	ipm_top #(.MS_DIV(5)) DUT (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_reset_n, .wake_pin, .rtc_event,
		.modem_registered, .lte_attached, .gnss_fix_ok, .gnss_meas_done, .gnss_sol_done,
		.lp_regulator_ff, .main_regulator_on_ff, .osc_on_ff, .rtc_on_ff, .cpu_clk_en,
		.modem_paging_ff, .modem_if_en_ff, .lte_pause_ff, .glonass_rf_on_ff, .rf_dsp_on_ff,
		.rf_dsp_partial_ff, .bb_clk_on_ff, .hot_start_ff);
	ipm_pin_drv u_pins (.core_clk, .go, .src, .pin_lvl, .ext_reset_n, .wake_pin, .rtc_event);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task complete_run;
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wt(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(negedge core_clk);
		for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
			@(negedge core_clk);
		rdat = wb_dat_o;
		chk(wb_ack_o, 1'b1);
		@(posedge core_clk);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(negedge core_clk);
	endtask
	task rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
	endtask
	task t_reset;
		rd(`IPM_STAT);
		chk(rdat[2:0], `IPM_M_RUN);
		chk(rdat[16:12], `IPM_G_ACQ);
		chk(cpu_clk_en, 1'b1);
		rd(8'h20);
		chk(rdat, 32'h0);
	endtask
	task t_lp;
		wb(1'b1, `IPM_CTRL, 32'h1);
		wt(4);
		chk(lp_regulator_ff, 1'b1);
		n = 0;
		repeat (200)
		begin
			@(negedge core_clk);
			n += cpu_clk_en;
		end
		chk(n, 4);
		rd(`IPM_STAT);
		chk(rdat[2:0], `IPM_M_LPR);
		wb(1'b1, `IPM_CTRL, 32'h3);
		wt(4);
		chk({lp_regulator_ff, cpu_clk_en}, 2'h1);
	endtask
	// pin first shows the wrong edge, so only the chosen polarity may wake
	task t_shd(input logic [1:0] s, input logic pol);
		@(posedge core_clk) pin_lvl <= pol;
		wb(1'b1, `IPM_BKUP, 32'h5a5a_1200 | s);
		wb(1'b1, `IPM_WAKE, {30'h0, 1'b1, pol});
		wb(1'b1, `IPM_CTRL, 32'h112);
		wt(6);
		chk({main_regulator_on_ff, osc_on_ff, rtc_on_ff, cpu_clk_en}, 4'h2);
		@(posedge core_clk) pin_lvl <= !pol;
		wt(6);
		chk(main_regulator_on_ff, 1'b0);
		@(posedge core_clk)
		begin
			src <= s;
			go <= (s != 2'h1);
			pin_lvl <= (s == 2'h1) ? pol : !pol;
		end
		@(posedge core_clk) go <= 1'b0;
		for (n = 0; n < 50 && main_regulator_on_ff !== 1'b1; n++)
			@(negedge core_clk);
		chk(main_regulator_on_ff, 1'b1);
		wt(4);
		rd(`IPM_STAT);
		chk(rdat[2:0], `IPM_M_RUN);
		rd(`IPM_BKUP);
		chk(rdat, 32'h5a5a_1200 | s);
		rd(`IPM_CTRL);
		chk(rdat[8:4], 5'h0);
	endtask
	task t_cell;
		@(posedge core_clk) modem_registered <= 1'b1;
		// paging is only kept in sleep when the modem was registered while idle
		wb(1'b1, `IPM_CELL, 32'h0);
		wt(4);
		wb(1'b1, `IPM_CELL, 32'h1);
		wt(4);
		rd(`IPM_STAT);
		chk({rdat[7:4], modem_paging_ff}, {`IPM_C_SLEEP, 1'b1});
		wb(1'b1, `IPM_CELL, 32'h3);
		wt(4);
		rd(`IPM_STAT);
		chk({rdat[7:4], modem_if_en_ff, modem_paging_ff}, {`IPM_C_PDN, 2'h0});
		wb(1'b1, `IPM_CELL, 32'h2);
		wt(4);
		rd(`IPM_STAT);
		chk(rdat[7:4], `IPM_C_DATA);
	endtask
	// one ms is 5 cycles here, so a pause is drx times 50 cycles
	task t_drx;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk) lte_attached <= 1'b0;
			wb(1'b1, `IPM_CELL, (i << 8) | 1);
			@(posedge core_clk) lte_attached <= 1'b1;
			for (n = 0; n < 14000 && lte_pause_ff !== 1'b1; n++)
				@(negedge core_clk);
			for (n = 0; n < 14000 && lte_pause_ff === 1'b1; n++)
				@(negedge core_clk);
			chk((n + 25) / 50, 32 << i);
		end
		@(posedge core_clk) lte_attached <= 1'b0;
	endtask
	task t_clamp;
		wb(1'b1, `IPM_CTRL, 32'h10);
		wb(1'b1, `IPM_TIME, {16'd100, 16'd20});
		rd(`IPM_TIME);
		chk(rdat, {16'd200, 16'd10});
		wb(1'b1, `IPM_TIME, {16'd1000, 16'd0});
		rd(`IPM_TIME);
		chk(rdat, {16'd900, 16'd1});
		wb(1'b1, `IPM_QMS, 32'h0000_c802);
		rd(`IPM_QMS);
		chk(rdat[15:0], 16'ha005);
		wb(1'b1, `IPM_QMS, 32'h07ff_0064);
		rd(`IPM_QMS);
		chk(rdat, 32'h07ff_0164);
		wb(1'b1, `IPM_CTRL, 32'h30);
		wb(1'b1, `IPM_TIME, {16'd300, 16'd5});
		rd(`IPM_TIME);
		chk(rdat, {16'd300, 16'd10});
		wb(1'b1, `IPM_CTRL, 32'h20);
		wb(1'b1, `IPM_TIME, {16'd300, 16'd9000});
		rd(`IPM_TIME);
		chk(rdat, {16'd300, 16'd7200});
		wb(1'b1, `IPM_CTRL, 32'h0);
	endtask
	task t_gnss;
		@(posedge core_clk) gnss_fix_ok <= 1'b0;
		wb(1'b1, `IPM_CTRL, 32'h200);
		wt(4);
		rd(`IPM_STAT);
		chk(rdat[16:12], `IPM_G_ACQ);
		@(posedge core_clk) gnss_fix_ok <= 1'b1;
		wt(4);
		rd(`IPM_STAT);
		chk(rdat[16:12], `IPM_G_TRK);
		wb(1'b1, `IPM_CTRL, 32'h300);
		wt(4);
		chk(glonass_rf_on_ff, 1'b0);
		wb(1'b1, `IPM_CTRL, 32'h0);
		wt(4);
		rd(`IPM_STAT);
		chk(rdat[16:12], `IPM_G_HIB);
		chk({rf_dsp_on_ff, bb_clk_on_ff, hot_start_ff}, 3'h1);
		wb(1'b1, `IPM_CTRL, 32'h200);
		wt(4);
		chk(rf_dsp_on_ff, 1'b1);
	endtask
	// receiver is tracking here; a 1 s trickle period is 5000 cycles from tracking entry
	task t_trickle;
		wb(1'b1, `IPM_CTRL, 32'h210);
		wb(1'b1, `IPM_TIME, {16'd200, 16'd1});
		@(posedge core_clk) gnss_meas_done <= 1'b1;
		wt(4);
		chk({rf_dsp_on_ff, rf_dsp_partial_ff, bb_clk_on_ff}, 3'h3);
		@(posedge core_clk) gnss_sol_done <= 1'b1;
		wt(4);
		chk({rf_dsp_on_ff, rf_dsp_partial_ff, bb_clk_on_ff}, 3'h0);
		@(posedge core_clk) {gnss_meas_done, gnss_sol_done} <= 2'h0;
		for (n = 0; n < 6000 && rf_dsp_on_ff !== 1'b1; n++)
			@(negedge core_clk);
		chk(rf_dsp_on_ff, 1'b1);
		chk(n / 500, 9);
	endtask
	initial
	begin
		{nrst, wb_cyc_i, wb_stb_i, wb_we_i, go, pin_lvl, src} = 8'h0;
		{modem_registered, lte_attached, gnss_fix_ok, gnss_meas_done, gnss_sol_done} = 5'h0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		mismatches = 0;
		tests_run = 0;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		wt(1);
		t_reset;
		t_lp;
		t_shd(2'h0, 1'b1);
		t_shd(2'h1, 1'b1);
		t_shd(2'h1, 1'b0);
		t_shd(2'h2, 1'b0);
		t_cell;
		t_drx;
		t_clamp;
		t_gnss;
		t_trickle;
		complete_run;
	end
	// about twice the expected run, mostly the four lte pauses
	initial
	begin
		#1000000;
		mismatches++;
		complete_run;
	end
endmodule // test_iot_power_mode_manager
bind ipm_top ipm_top_chk #(.MS_DIV(MS_DIV)) u_chk (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .ext_reset_n, .lte_attached, .lp_regulator_ff, .main_regulator_on_ff,
	.osc_on_ff, .cpu_clk_en, .modem_paging_ff, .modem_if_en_ff, .lte_pause_ff,
	.rf_dsp_on_ff, .rf_dsp_partial_ff, .bb_clk_on_ff);
